// *** dtu_defs.svh ***
`ifndef DTU_DEFS_SVH
`define DTU_DEFS_SVH

// ------------------------------------------------------------
// counter geometry
// ------------------------------------------------------------
`define DTU_CNT_W      16
`define DTU_CNT_ZERO   16'h0000
`define DTU_CNT_MAX    16'hFFFF
`define DTU_CNT_ONE    16'h0001

// ------------------------------------------------------------
// prescaler: finest step is two system clocks, shifted by 0..7
// ------------------------------------------------------------
`define DTU_PRE_W      8
`define DTU_PRE_SEL_W  3
`define DTU_BASE_MASK  8'h01
`define DTU_DIV_ZERO   8'h00
`define DTU_DIV_ONE    8'h01

// ------------------------------------------------------------
// synchronised pin vector layout
// ------------------------------------------------------------
`define DTU_PIN_N      7
`define DTU_PIN_ZERO   7'h00
`define DTU_PIN_CCNT   0
`define DTU_PIN_CDIR   1
`define DTU_PIN_ACNT   2
`define DTU_PIN_ADIR   3
`define DTU_PIN_CAP    4
`define DTU_PIN_SCNT   5
`define DTU_PIN_SDIR   6

`endif

// *** dtu_pkg.sv ***
package dtu_pkg;
  // count source of either timer; latch only valid for the auxiliary timer
  typedef enum logic [1:0] {
    DTU_SRC_PRESCALE,
    DTU_SRC_PIN,
    DTU_SRC_LATCH,
    DTU_SRC_OFF
  } dtu_src_t;
endpackage

// *** dtu_tmr_if.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
interface dtu_tmr_if;
  logic                   count_en;
  logic                   up;
  logic                   load;
  logic [`DTU_CNT_W-1:0]  load_val;
  logic                   clear;
  logic [`DTU_CNT_W-1:0]  value;
  logic                   wrap;

  modport ctl (output count_en, output up, output load, output load_val, output clear,
               input value, input wrap);
  modport tmr (input count_en, input up, input load, input load_val, input clear,
               output value, output wrap);
endinterface

// *** dtu_timer.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
module dtu_timer
  import dtu_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  dtu_tmr_if.tmr    t
);
  logic [`DTU_CNT_W-1:0] cnt_q;
  logic [`DTU_CNT_W-1:0] cnt_d;

  // ------------------------------------------------------------
  // overflow going up, underflow going down
  // ------------------------------------------------------------
  assign t.wrap  = t.count_en & (t.up ? (cnt_q == `DTU_CNT_MAX) : (cnt_q == `DTU_CNT_ZERO));
  assign t.value = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (t.clear) begin
      cnt_d = `DTU_CNT_ZERO;
    end else if (t.wrap && t.load) begin
      cnt_d = t.load_val;
    end else if (t.count_en) begin
      cnt_d = t.up ? cnt_q + `DTU_CNT_ONE : cnt_q - `DTU_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt_q <= `DTU_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** dtu_top.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
// Contract
// - finest count step is two system clock cycles
// - two independent timers, core and auxiliary, plus a shared capture/reload register
// - each timer counts prescaled system clock or an external pin
// - direction from a software bit or from the timer's direction pin
// - core toggle latch inverts on every core overflow or underflow
// - toggle latch can clock the auxiliary timer and drive an output pin
// - core overflow/underflow offered as clock to the compare unit timers
// - when enabled, core wrap reloads core timer from capture/reload register
// - selected capture pin edge copies auxiliary count into capture/reload register
// - optionally clear auxiliary timer right after each capture
// - capture may instead be triggered by sibling count and/or direction input edges
module dtu_top
  import dtu_pkg::*;
(
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_b_i,
  // core timer control
  input  wire logic [1:0]                core_src_i,
  input  wire logic [`DTU_PRE_SEL_W-1:0] core_prescale_i,
  input  wire logic                      core_up_i,
  input  wire logic                      core_dir_pin_en_i,
  input  wire logic                      reload_en_i,
  input  wire logic                      toggle_pin_en_i,
  // auxiliary timer control
  input  wire logic [1:0]                aux_src_i,
  input  wire logic [`DTU_PRE_SEL_W-1:0] aux_prescale_i,
  input  wire logic                      aux_up_i,
  input  wire logic                      aux_dir_pin_en_i,
  // capture control
  input  wire logic                      capture_rise_en_i,
  input  wire logic                      capture_fall_en_i,
  input  wire logic                      capture_clear_en_i,
  input  wire logic                      sibling_count_cap_en_i,
  input  wire logic                      sibling_dir_cap_en_i,
  input  wire logic                      capture_reload_reg_wr_i,
  input  wire logic [`DTU_CNT_W-1:0]     capture_reload_reg_wdata_i,
  // pins
  input  wire logic                      core_count_pin_i,
  input  wire logic                      core_direction_pin_i,
  input  wire logic                      aux_count_pin_i,
  input  wire logic                      aux_direction_pin_i,
  input  wire logic                      capture_pin_i,
  input  wire logic                      sibling_count_input_i,
  input  wire logic                      sibling_direction_input_i,
  // results
  output logic [`DTU_CNT_W-1:0]          core_count_o,
  output logic [`DTU_CNT_W-1:0]          aux_count_o,
  output logic [`DTU_CNT_W-1:0]          capture_reload_o,
  output logic                           toggle_latch_pin_o,
  output logic                           compare_clk_o,
  output logic                           capture_evt_o
);
  dtu_tmr_if core_if();
  dtu_tmr_if aux_if();

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic [`DTU_PIN_N-1:0] pin_raw;
  logic [`DTU_PIN_N-1:0] meta_q;
  logic [`DTU_PIN_N-1:0] sync_q;
  logic [`DTU_PIN_N-1:0] prev_q;
  logic [`DTU_PIN_N-1:0] rise;
  logic [`DTU_PIN_N-1:0] fall;

  assign pin_raw = {sibling_direction_input_i, sibling_count_input_i, capture_pin_i,
                    aux_direction_pin_i, aux_count_pin_i, core_direction_pin_i,
                    core_count_pin_i};
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // meta_q is read only by sync_q, edges come from the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      meta_q <= `DTU_PIN_ZERO;
      sync_q <= `DTU_PIN_ZERO;
      prev_q <= `DTU_PIN_ZERO;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  logic [`DTU_PRE_W-1:0] div_q;
  logic [`DTU_PRE_W-1:0] div_d;
  logic [`DTU_PRE_W-1:0] core_mask;
  logic [`DTU_PRE_W-1:0] aux_mask;
  logic                  core_tick;
  logic                  aux_tick;

  // base divide is two clocks, each prescale step doubles it
  assign core_mask = `DTU_PRE_W'((`DTU_BASE_MASK << core_prescale_i) | ((`DTU_BASE_MASK <<
                     core_prescale_i) - `DTU_DIV_ONE));
  assign aux_mask  = `DTU_PRE_W'((`DTU_BASE_MASK << aux_prescale_i) | ((`DTU_BASE_MASK <<
                     aux_prescale_i) - `DTU_DIV_ONE));
  assign core_tick = (div_q & core_mask) == core_mask;
  assign aux_tick  = (div_q & aux_mask) == aux_mask;
  assign div_d     = div_q + `DTU_DIV_ONE;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      div_q <= `DTU_DIV_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  // ------------------------------------------------------------
  // timers, toggle latch, capture/reload
  // ------------------------------------------------------------
  logic                  latch_q;
  logic                  latch_d;
  logic                  latch_prev_q;
  logic                  latch_evt;
  logic [`DTU_CNT_W-1:0] capture_reload_reg_q;
  logic [`DTU_CNT_W-1:0] capture_reload_reg_d;
  logic                  cap_evt;
  logic                  tpin_q;
  logic                  tpin_d;
  logic                  cmp_q;
  logic                  cmp_d;
  logic                  cap_o_q;
  logic                  cap_o_d;
  logic [`DTU_CNT_W-1:0] core_o_q;
  logic [`DTU_CNT_W-1:0] aux_o_q;
  dtu_src_t              core_src;
  dtu_src_t              aux_src;

  assign core_src  = dtu_src_t'(core_src_i);
  assign aux_src   = dtu_src_t'(aux_src_i);
  // the latch is registered, so the auxiliary timer sees a core wrap one clock late
  assign latch_evt = latch_q ^ latch_prev_q;

  // pin edges feed the capture, sibling inputs as an alternative source
  assign cap_evt = (capture_rise_en_i & rise[`DTU_PIN_CAP])
                 | (capture_fall_en_i & fall[`DTU_PIN_CAP])
                 | (sibling_count_cap_en_i & (rise[`DTU_PIN_SCNT] | fall[`DTU_PIN_SCNT]))
                 | (sibling_dir_cap_en_i & (rise[`DTU_PIN_SDIR] | fall[`DTU_PIN_SDIR]));

  always_comb begin
    unique case (core_src)
      DTU_SRC_PRESCALE: core_if.count_en = core_tick;
      DTU_SRC_PIN:      core_if.count_en = rise[`DTU_PIN_CCNT];
      default:          core_if.count_en = 1'b0;
    endcase
    unique case (aux_src)
      DTU_SRC_PRESCALE: aux_if.count_en = aux_tick;
      DTU_SRC_PIN:      aux_if.count_en = rise[`DTU_PIN_ACNT];
      DTU_SRC_LATCH:    aux_if.count_en = latch_evt;
      default:          aux_if.count_en = 1'b0;
    endcase
    core_if.up       = core_dir_pin_en_i ? sync_q[`DTU_PIN_CDIR] : core_up_i;
    aux_if.up        = aux_dir_pin_en_i ? sync_q[`DTU_PIN_ADIR] : aux_up_i;
    core_if.load     = reload_en_i;
    core_if.load_val = capture_reload_reg_q;
    core_if.clear    = 1'b0;
    aux_if.load      = 1'b0;
    aux_if.load_val  = `DTU_CNT_ZERO;
    aux_if.clear     = cap_evt & capture_clear_en_i;
    latch_d  = latch_q ^ core_if.wrap;
    tpin_d   = toggle_pin_en_i & latch_q;
    cmp_d    = core_if.wrap;
    cap_o_d  = cap_evt;
    // hardware capture beats a software write in the same clock
    capture_reload_reg_d = capture_reload_reg_q;
    if (cap_evt) begin
      capture_reload_reg_d = aux_if.value;
    end else if (capture_reload_reg_wr_i) begin
      capture_reload_reg_d = capture_reload_reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      latch_q      <= 1'b0;
      latch_prev_q <= 1'b0;
      capture_reload_reg_q     <= `DTU_CNT_ZERO;
      tpin_q       <= 1'b0;
      cmp_q        <= 1'b0;
      cap_o_q      <= 1'b0;
      core_o_q     <= `DTU_CNT_ZERO;
      aux_o_q      <= `DTU_CNT_ZERO;
    end else begin
      latch_q      <= latch_d;
      latch_prev_q <= latch_q;
      capture_reload_reg_q     <= capture_reload_reg_d;
      tpin_q       <= tpin_d;
      cmp_q        <= cmp_d;
      cap_o_q      <= cap_o_d;
      core_o_q     <= core_if.value;
      aux_o_q      <= aux_if.value;
    end
  end

  dtu_timer u_core (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .t         (core_if.tmr)
  );

  dtu_timer u_aux (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .t         (aux_if.tmr)
  );

  assign core_count_o       = core_o_q;
  assign aux_count_o        = aux_o_q;
  assign capture_reload_o   = capture_reload_reg_q;
  assign toggle_latch_pin_o = tpin_q;
  assign compare_clk_o      = cmp_q;
  assign capture_evt_o      = cap_o_q;
endmodule

// *** dtu_properties.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
module dtu_properties
  import dtu_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_b_i,
  input wire logic [1:0]            core_src_i,
  input wire logic                  core_up_i,
  input wire logic                  core_dir_pin_en_i,
  input wire logic                  reload_en_i,
  input wire logic                  toggle_pin_en_i,
  input wire logic                  capture_clear_en_i,
  input wire logic                  capture_reload_reg_wr_i,
  input wire logic [`DTU_CNT_W-1:0] core_count_o,
  input wire logic [`DTU_CNT_W-1:0] aux_count_o,
  input wire logic [`DTU_CNT_W-1:0] capture_reload_o,
  input wire logic                  toggle_latch_pin_o,
  input wire logic                  compare_clk_o,
  input wire logic                  capture_evt_o
);
  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_cap_clr;
    capture_evt_o && capture_clear_en_i && $past(capture_clear_en_i);
  endsequence
  sequence s_core_up;
    $past(core_up_i, 2) && !$past(core_dir_pin_en_i, 2) && !$past(reload_en_i, 2);
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_CMP_PULSE: assert property (compare_clk_o |=> !compare_clk_o)
    else $error("compare clock pulse too long");
  AST_CAP_PULSE: assert property (capture_evt_o |=> !capture_evt_o)
    else $error("capture event pulse too long");
  AST_CAP_CLEAR: assert property (s_cap_clr |=> aux_count_o == `DTU_CNT_ZERO)
    else $error("aux timer not cleared after capture");
  AST_CAP_SRC: assert property ($changed(capture_reload_o) |->
    capture_evt_o || $past(capture_reload_reg_wr_i) || $past(capture_reload_reg_wr_i, 2))
    else $error("capture register changed without cause");
  AST_TGL_GATE: assert property (!$past(toggle_pin_en_i) |-> !toggle_latch_pin_o)
    else $error("toggle pin driven while disabled");
  AST_TGL_WRAP: assert property (toggle_pin_en_i && $past(toggle_pin_en_i) &&
    $past(toggle_pin_en_i, 2) && $changed(toggle_latch_pin_o) |->
    compare_clk_o || $past(compare_clk_o))
    else $error("toggle latch changed without wrap");
  AST_CORE_UP: assert property (s_core_up ##0 $changed(core_count_o) |->
    core_count_o == $past(core_count_o) + `DTU_CNT_ONE)
    else $error("core up step not plus one");
  AST_CORE_GAP: assert property ($changed(core_count_o) |=> $stable(core_count_o))
    else $error("core stepped faster than two clocks");
  AST_CORE_FROZEN: assert property ($past(core_src_i[1]) && $past(core_src_i[1], 2) &&
    $past(core_src_i[1], 3) |-> $stable(core_count_o))
    else $error("core moved while stopped");
endmodule
bind dtu_top dtu_properties i_props (.*);

// *** dtu_pin_model.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
module dtu_pin_model (
  input  wire logic              ref_clk_i,
  output logic [`DTU_PIN_N-1:0]  pins_o
);
  initial pins_o = `DTU_PIN_ZERO;
  task automatic set_pin(input int k, input logic lvl);
    @(negedge ref_clk_i);
    pins_o[k] = lvl;
  endtask
  // three clocks each way, above the two-clock minimum
  task automatic pulse(input int k);
    set_pin(k, 1'b1);
    repeat (2) @(negedge ref_clk_i);
    set_pin(k, 1'b0);
    repeat (2) @(negedge ref_clk_i);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
`include "dtu_defs.svh"
module tb;
  import dtu_pkg::*;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0;
  logic [1:0]  core_src_i = 2'h2, aux_src_i = 2'h3;
  logic [2:0]  core_prescale_i = 3'h0, aux_prescale_i = 3'h0;
  logic        core_up_i = 1'b1, core_dir_pin_en_i = 1'b0, reload_en_i = 1'b0;
  logic        toggle_pin_en_i = 1'b0, aux_up_i = 1'b1, aux_dir_pin_en_i = 1'b0;
  logic        capture_rise_en_i = 1'b0, capture_fall_en_i = 1'b0, capture_clear_en_i = 1'b0;
  logic        sibling_count_cap_en_i = 1'b0, sibling_dir_cap_en_i = 1'b0, capture_reload_reg_wr_i = 1'b0;
  logic [15:0] capture_reload_reg_wdata_i = 16'h0000;
  logic [15:0] core_count_o, aux_count_o, capture_reload_o;
  logic        toggle_latch_pin_o, compare_clk_o, capture_evt_o;
  wire  [`DTU_PIN_N-1:0] pins;
  wire  core_count_pin_i = pins[`DTU_PIN_CCNT], core_direction_pin_i = pins[`DTU_PIN_CDIR];
  wire  aux_count_pin_i = pins[`DTU_PIN_ACNT], aux_direction_pin_i = pins[`DTU_PIN_ADIR];
  wire  capture_pin_i = pins[`DTU_PIN_CAP], sibling_count_input_i = pins[`DTU_PIN_SCNT];
  wire  sibling_direction_input_i = pins[`DTU_PIN_SDIR];
  int   bad_count = 0, checks = 0;
  int   trig [4] = '{`DTU_PIN_CAP, `DTU_PIN_CAP, `DTU_PIN_SCNT, `DTU_PIN_SDIR};
  dtu_top       i_dut (.*);
  dtu_pin_model i_pins (.ref_clk_i(ref_clk_i), .pins_o(pins));
  always #50 ref_clk_i = ~ref_clk_i;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] get(input int s);
    case (s)
      0:       get = core_count_o;
      1:       get = aux_count_o;
      2:       get = {15'h0000, compare_clk_o};
      default: get = {15'h0000, capture_evt_o};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // look just after each rising edge; hand back at a falling edge
  task automatic wait_for(input int s, input bit hi, output int c);
    logic [15:0] v;
    v = get(s);
    c = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      c++;
    end while ((hi ? get(s) !== 16'h0001 : get(s) === v) && c < 300);
    // a wait that runs out is a mismatch of its own
    if (hi ? get(s) !== 16'h0001 : get(s) === v) begin
      bad_count++;
      $display("BAD wait %0d exp event got none", s);
    end
    @(negedge ref_clk_i);
  endtask
  task automatic rst(input logic [1:0] cs);
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    core_src_i = cs;
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic test_done();
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int   c;
    logic t0;
    logic [15:0] v0;
    rst(2'h2);
    core_up_i = 1'b0;
    core_src_i = 2'h0;
    wait_for(0, 0, c);
    chk("core down wrap", 16'hffff, core_count_o);
    wait_for(0, 0, c);
    chk("core down", 16'hfffe, core_count_o);
    core_dir_pin_en_i = 1'b1;
    i_pins.set_pin(`DTU_PIN_CDIR, 1'b1);
    rst(2'h2);
    core_src_i = 2'h0;
    wait_for(0, 0, c);
    chk("core pin up", 16'h0001, core_count_o);
    core_dir_pin_en_i = 1'b0;
    core_up_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      core_prescale_i = 3'(i);
      wait_for(0, 0, c);
      wait_for(0, 0, c);
      chk("core period", 16'(2 << i), 16'(c));
    end
    rst(2'h2);
    core_src_i = 2'h1;
    aux_src_i = 2'h1;
    capture_clear_en_i = 1'b1;
    for (int i = 0; i < 3; i++) i_pins.pulse(`DTU_PIN_CCNT);
    repeat (4) @(negedge ref_clk_i);
    chk("core pin count", 16'h0003, core_count_o);
    for (int i = 0; i < 4; i++) begin
      repeat (i + 2) i_pins.pulse(`DTU_PIN_ACNT);
      capture_rise_en_i = (i == 0);
      capture_fall_en_i = (i == 1);
      sibling_count_cap_en_i = (i == 2);
      sibling_dir_cap_en_i = (i == 3);
      i_pins.set_pin(trig[i], i != 1);
      wait_for(3, 1, c);
      chk("capture", 16'(i + 2), capture_reload_o);
      @(negedge ref_clk_i);
      chk("aux cleared", 16'h0000, aux_count_o);
    end
    capture_reload_reg_wdata_i = 16'h0003;
    capture_reload_reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    capture_reload_reg_wr_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("capture_reload_reg write", 16'h0003, capture_reload_o);
    core_up_i = 1'b0;
    reload_en_i = 1'b1;
    toggle_pin_en_i = 1'b1;
    core_src_i = 2'h0;
    aux_src_i = 2'h2;
    // finest step, so reload value 3 gives four ticks of two clocks
    core_prescale_i = 3'h0;
    wait_for(2, 1, c);
    wait_for(2, 1, c);
    t0 = toggle_latch_pin_o;
    chk("reload period", 16'h0008, 16'(c));
    wait_for(2, 1, c);
    chk("latch toggles", {15'h0000, ~t0}, {15'h0000, toggle_latch_pin_o});
    wait_for(1, 0, c);
    wait_for(1, 0, c);
    chk("aux on latch", 16'h0008, 16'(c));
    aux_dir_pin_en_i = 1'b1;
    aux_prescale_i = 3'h1;
    aux_src_i = 2'h0;
    wait_for(1, 0, c);
    v0 = aux_count_o;
    wait_for(1, 0, c);
    chk("aux prescale period", 16'h0004, 16'(c));
    chk("aux pin down", 16'(v0 - 16'h0001), aux_count_o);
    test_done();
  end
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule
